// >>> src/idc_consts.svh
/*
  Constants of the increment/decrement, loop and interrupt slice of
  the core: register indices, field positions, bus offsets, resets.
  Assumes a byte-wide register file of 256 entries in the core.
*/
// Behaviour
// - Step ops set zero, sign, overflow
// - Step ops keep carry, decimal, half-carry
// - Global off clears mask bit 7 only
// - Global on sets mask bit 7
// - Loop decrements counter, branches if nonzero
// - Signed byte added to next address
// - Counter zero falls through to next
// - Off, on, loop, halt keep flags
// - Halt stops core, bus stays served
// - Interrupt or reset leaves halt
// - Halt needs no preceding no-operation
// - Byte increment, direct and indirect
// - Word increment on even pair
// - Return pops flags, counter, sets enable
// - Stack pointer advances one, then two
`ifndef IDC_CONSTS_SVH
`define IDC_CONSTS_SVH
`define IDC_IRQ_MASK_IDX 8'hfb
`define IDC_FLAGS_IDX 8'hfc
`define IDC_RPTR_IDX  8'hfd
`define IDC_STACK_LO_IDX 8'hff
`define IDC_CMD_ADR   12'h400
`define IDC_PC_ADR    12'h404
`define IDC_STAT_ADR  12'h408
`define IDC_GIE_BIT   7
`define IDC_FC        7
`define IDC_FZ        6
`define IDC_FS        5
`define IDC_FV        4
`define IDC_FD        3
`define IDC_FH        2
`define IDC_ST_HALT   0
`define IDC_ST_BUSY   1
`define IDC_WORK_NIB  4'he
`define IDC_INCR_NIB  4'he
`define IDC_LOOP_NIB  4'ha
`define IDC_RESET_BYTE 8'h00
`define IDC_RESET_PC  16'h0000
`endif

// >>> src/idc_pkg.sv
/*
  Types of the slice: control states, opcodes and operation kinds.
  Assumes the constants header is included by the user files.
*/
package idc_pkg;
  typedef enum logic [3:0] {
    ST_IDLE   = 4'b0001,
    ST_EXEC   = 4'b0010,
    ST_POP_PC = 4'b0100,
    ST_HALT   = 4'b1000
  } idc_state_type;

  typedef enum logic [7:0] {
    OPC_INC_R   = 8'h20,
    OPC_INC_IR  = 8'h21,
    OPC_PINC_RR = 8'ha0,
    OPC_PINC_IR = 8'ha1,
    OPC_PDEC_RR = 8'h80,
    OPC_PDEC_IR = 8'h81,
    OPC_IRQ_OFF = 8'h8f,
    OPC_IRQ_ON  = 8'h9f,
    OPC_HALT    = 8'h7f,
    OPC_RET_ISR = 8'hbf
  } idc_opc_type;

  typedef enum logic [3:0] {
    K_NONE, K_INC, K_PINC, K_PDEC, K_OFF, K_ON, K_LOOP, K_HALT, K_RET
  } idc_kind_type;
endpackage

// >>> src/idc_step_unit.sv
/*
  Add or subtract one on a byte or a register pair, with flag results.
  Assumes the caller stores the result and merges the flags.
*/
`timescale 1ns/1ps
module idc_step_unit
  import idc_pkg::*;
(
  input  wire logic [15:0] val,
  input  wire logic        word,
  input  wire logic        dec,
  output logic      [15:0] res,
  output logic             z,
  output logic             s,
  output logic             v
);
  assign res = dec ? val - 16'h0001 : val + 16'h0001;

  always_comb
  begin
    if (word)
    begin
      z = (res == 16'h0000);
      s = res[15];
      v = dec ? (res == 16'h7fff) : (res == 16'h8000);
    end
    else
    begin
      z = (res[7:0] == 8'h00);
      s = res[7];
      v = (res[7:0] == 8'h80); // Set on a low byte of 80: 7f+1, or 81-1 when dec
    end
  end
endmodule

// >>> src/idc_loop_unit.sv
/*
  Loop counter decrement and relative branch target.
  Assumes pc holds the address of the loop opcode, two bytes long.
*/
`timescale 1ns/1ps
module idc_loop_unit
  import idc_pkg::*;
(
  input  wire logic [15:0] pc,
  input  wire logic [7:0]  disp,
  input  wire logic [7:0]  cnt,
  output logic      [7:0]  cnt_next,
  output logic             taken,
  output logic      [15:0] pc_next
);
  logic [15:0] pc_follow;

  assign cnt_next  = cnt - 8'h01;
  assign taken     = (cnt_next != 8'h00);
  assign pc_follow = pc + 16'h0002;
  assign pc_next   = taken ? pc_follow + {{8{disp[7]}}, disp}
                           : pc_follow;
endmodule

// >>> src/idc_core.sv
/*
  Execution slice of an 8-bit core: byte/word increment, word
  decrement, global interrupt off/on, counted loop branch, halt and
  return from interrupt, over a flip-flop register file.
  Software reaches the register file, the instruction port, the
  program counter and status over a classic Wishbone slave; an
  outside interrupt controller raises irq_wake to end a halt.
*/
// Our own choice: register access over Wishbone.
`timescale 1ns/1ps
`include "idc_consts.svh"
module idc_core
  import idc_pkg::*;
#(
  parameter int ADR_W = 12
)
(
  input  wire logic             core_clk,
  input  wire logic             rst,
  input  wire logic             wb_cyc_i,
  input  wire logic             wb_stb_i,
  input  wire logic             wb_we_i,
  input  wire logic [ADR_W-1:0] wb_adr_i,
  input  wire logic [3:0]       wb_sel_i,
  input  wire logic [31:0]      wb_dat_i,
  output logic      [31:0]      wb_dat_o,
  output logic                  wb_ack_o,
  input  wire logic             irq_wake,
  output logic                  cpu_clk_en,
  output logic                  irq_global_en
);
  // Address map needs twelve bits at least
  if (ADR_W < 12)
  begin : g_adr_check
    $error("idc_core needs ADR_W of 12 or more");
  end

  logic [7:0]    mem [256];
  idc_state_type state;
  idc_state_type next_state;
  idc_kind_type  kind;
  logic [7:0]    opc;
  logic [7:0]    opd;
  logic [15:0]   pc;
  logic [7:0]    rp_q;
  logic [7:0]    flags_q;
  logic [7:0]    irq_mask_q;
  logic [7:0]    stack_lo_q;
  logic [7:0]    work_a;
  logic [7:0]    dir_a;
  logic [7:0]    ea;
  logic [7:0]    hi_a;
  logic [7:0]    lo_a;
  logic          is_word;
  logic [15:0]   step_val;
  logic [15:0]   step_res;
  logic          step_z;
  logic          step_s;
  logic          step_v;
  logic [7:0]    cnt_next;
  logic          loop_taken;
  logic [15:0]   loop_pc;
  logic [11:0]   adr;
  logic          adr_ok;
  logic          in_regs;
  logic          wb_req;
  logic          wb_take;
  logic          wb_wr;
  logic          cmd_go;
  logic [15:0]   pc_len;

  // Working register names carry the marker nibble in the high half
  function automatic logic [7:0] eff_addr(input logic [7:0] a,
                                          input logic [7:0] rp);
    eff_addr = (a[7:4] == `IDC_WORK_NIB) ? {rp[7:4], a[3:0]} : a;
  endfunction

  // Opcode to operation kind; unknown codes run as one-byte no-ops
  function automatic idc_kind_type op_kind(input logic [7:0] o);
    op_kind = K_NONE;
    if (o[3:0] == `IDC_INCR_NIB)
      op_kind = K_INC;
    else if (o[3:0] == `IDC_LOOP_NIB)
      op_kind = K_LOOP;
    else
    begin
      case (o)
        OPC_INC_R, OPC_INC_IR:     op_kind = K_INC;
        OPC_PINC_RR, OPC_PINC_IR:  op_kind = K_PINC;
        OPC_PDEC_RR, OPC_PDEC_IR:  op_kind = K_PDEC;
        OPC_IRQ_OFF:               op_kind = K_OFF;
        OPC_IRQ_ON:                op_kind = K_ON;
        OPC_HALT:                  op_kind = K_HALT;
        OPC_RET_ISR:               op_kind = K_RET;
        default:                   op_kind = K_NONE;
      endcase
    end
  endfunction

  // Named control registers live inside the register file
  assign rp_q    = mem[`IDC_RPTR_IDX];
  assign flags_q = mem[`IDC_FLAGS_IDX];
  assign irq_mask_q = mem[`IDC_IRQ_MASK_IDX];
  assign stack_lo_q = mem[`IDC_STACK_LO_IDX];
  assign irq_global_en = mem[`IDC_IRQ_MASK_IDX][`IDC_GIE_BIT];

  // Operand addressing: short working form, direct, or indirect
  assign kind   = op_kind(opc);
  assign work_a = {rp_q[7:4], opc[7:4]};
  assign dir_a  = eff_addr(opd, rp_q);
  assign ea     = (opc[3:0] == `IDC_INCR_NIB) ? work_a
                : (opc[0] ? mem[dir_a] : dir_a);
  assign hi_a   = {ea[7:1], 1'b0};
  assign lo_a   = {ea[7:1], 1'b1};
  assign is_word  = (kind == K_PINC) || (kind == K_PDEC);
  assign step_val = is_word ? {mem[hi_a], mem[lo_a]} : {8'h00, mem[ea]};

  idc_step_unit u_step (
    .val  (step_val),
    .word (is_word),
    .dec  (kind == K_PDEC),
    .res  (step_res),
    .z    (step_z),
    .s    (step_s),
    .v    (step_v)
  );

  idc_loop_unit u_loop (
    .pc       (pc),
    .disp     (opd),
    .cnt      (mem[work_a]),
    .cnt_next (cnt_next),
    .taken    (loop_taken),
    .pc_next  (loop_pc)
  );

  // Bus decode; the core owns the file while it executes, so the bus
  // waits for idle or halt rather than racing the datapath
  assign adr     = wb_adr_i[11:0];
  assign adr_ok  = ((wb_adr_i >> 12) == '0);
  assign in_regs = adr_ok && (adr[11:10] == 2'b00);
  assign wb_req  = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign wb_take = wb_req && (state == ST_IDLE || state == ST_HALT);
  assign wb_wr   = wb_take && wb_we_i;
  assign cmd_go  = wb_wr && adr_ok && (adr == `IDC_CMD_ADR)
                && wb_sel_i[0] && (state == ST_IDLE);

  // Bytes taken by the instruction just run
  assign pc_len = ((kind == K_INC && opc[3:0] != `IDC_INCR_NIB)
                || is_word) ? 16'h0002 : 16'h0001;

  // Next control state
  always_comb
  begin
    next_state = state;
    unique case (state)
      ST_IDLE:   if (cmd_go) next_state = ST_EXEC;
      ST_EXEC:   next_state = (kind == K_HALT) ? ST_HALT
                            : (kind == K_RET) ? ST_POP_PC : ST_IDLE;
      ST_POP_PC: next_state = ST_IDLE;
      ST_HALT:   if (irq_wake) next_state = ST_IDLE;
      default:   next_state = ST_IDLE;
    endcase
  end

  always_ff @(posedge core_clk)
  begin
    if (rst)
      state <= ST_IDLE;
    else
      state <= next_state;
  end

  // core clock gated off in halt
  always_ff @(posedge core_clk)
  begin
    if (rst)
      cpu_clk_en <= 1'b1;
    else
      cpu_clk_en <= (next_state != ST_HALT);
  end

  // Instruction port latch
  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      opc <= `IDC_RESET_BYTE;
      opd <= `IDC_RESET_BYTE;
    end
    else if (cmd_go)
    begin
      opc <= wb_dat_i[7:0];
      opd <= wb_dat_i[15:8];
    end
  end

  // Program counter
  always_ff @(posedge core_clk)
  begin
    if (rst)
      pc <= `IDC_RESET_PC;
    else if (wb_wr && adr_ok && adr == `IDC_PC_ADR && state == ST_IDLE)
    begin
      if (wb_sel_i[0])
        pc[7:0] <= wb_dat_i[7:0];
      if (wb_sel_i[1])
        pc[15:8] <= wb_dat_i[15:8];
    end
    else if (state == ST_EXEC && kind != K_RET)
    begin
      if (kind == K_LOOP)
        pc <= loop_pc;
      else
        pc <= pc + pc_len;
    end
    else if (state == ST_POP_PC)
      pc <= {mem[stack_lo_q], mem[stack_lo_q + 8'h01]};
  end

  // Register file: bus writes, then datapath results; a flags write
  // comes last so it wins when the destination is the flags byte
  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      for (int i = 0; i < 256; i++)
        mem[i] <= `IDC_RESET_BYTE;
    end
    else if (wb_wr && in_regs && wb_sel_i[0])
      mem[adr[9:2]] <= wb_dat_i[7:0];
    else if (state == ST_EXEC)
    begin
      unique case (kind)
        K_INC, K_PINC, K_PDEC:
        begin
          if (is_word)
          begin
            // even byte high, odd byte low
            mem[hi_a] <= step_res[15:8];
            mem[lo_a] <= step_res[7:0];
          end
          else
            mem[ea] <= step_res[7:0];
          mem[`IDC_FLAGS_IDX][`IDC_FZ] <= step_z;
          mem[`IDC_FLAGS_IDX][`IDC_FS] <= step_s;
          mem[`IDC_FLAGS_IDX][`IDC_FV] <= step_v;
        end
        K_OFF: mem[`IDC_IRQ_MASK_IDX][`IDC_GIE_BIT] <= 1'b0;
        K_ON:  mem[`IDC_IRQ_MASK_IDX][`IDC_GIE_BIT] <= 1'b1;
        K_LOOP: mem[work_a] <= cnt_next;
        K_RET:
        begin
          mem[`IDC_FLAGS_IDX]    <= mem[stack_lo_q];
          mem[`IDC_STACK_LO_IDX] <= stack_lo_q + 8'h01;
        end
        K_HALT, K_NONE: ;
      endcase
    end
    else if (state == ST_POP_PC)
    begin
      // two more after the flags pop
      mem[`IDC_STACK_LO_IDX] <= stack_lo_q + 8'h02;
      mem[`IDC_IRQ_MASK_IDX][`IDC_GIE_BIT] <= 1'b1;
    end
  end

  // Bus answer: one wait state at least, unmapped reads give zero
  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end
    else
    begin
      wb_ack_o <= wb_take;
      if (wb_take && !wb_we_i)
      begin
        if (in_regs)
          wb_dat_o <= {24'h00_0000, mem[adr[9:2]]};
        else if (adr_ok && adr == `IDC_PC_ADR)
          wb_dat_o <= {16'h0000, pc};
        else if (adr_ok && adr == `IDC_CMD_ADR)
          wb_dat_o <= {16'h0000, opd, opc};
        else if (adr_ok && adr == `IDC_STAT_ADR)
          wb_dat_o <= {30'h0, state != ST_IDLE && state != ST_HALT,
                       state == ST_HALT};
        else
          wb_dat_o <= 32'h0000_0000;
      end
    end
  end

  // zero flag tied to stored byte
  a_inc_zero_flag:
  assert property (@(posedge core_clk) disable iff (rst)
    (state == ST_EXEC && kind == K_INC && ea != `IDC_FLAGS_IDX) |=>
    (flags_q[`IDC_FZ] == (mem[$past(ea)] == 8'h00)))
    else $error("Zero flag does not match incremented byte");

  a_step_keeps_cdh:
  assert property (@(posedge core_clk) disable iff (rst)
    (state == ST_EXEC && (kind == K_INC || is_word)) |=>
    ({flags_q[`IDC_FC], flags_q[`IDC_FD], flags_q[`IDC_FH]} ==
     {$past(flags_q[`IDC_FC]), $past(flags_q[`IDC_FD]),
      $past(flags_q[`IDC_FH])}))
    else $error("Step changed carry, decimal or half-carry");

  a_off_keeps_levels:
  assert property (@(posedge core_clk) disable iff (rst)
    (state == ST_EXEC && kind == K_OFF) |=>
    (!irq_global_en && irq_mask_q[6:0] == $past(irq_mask_q[6:0])))
    else $error("Global off did not clear only bit seven");

  a_on_sets_enable:
  assert property (@(posedge core_clk) disable iff (rst)
    (state == ST_EXEC && kind == K_ON) |=> irq_global_en ##1 1'b1)
    else $error("Global on did not set the enable");

  // taken branch lands at next address plus displacement
  a_loop_target:
  assert property (@(posedge core_clk) disable iff (rst)
    (state == ST_EXEC && kind == K_LOOP && mem[work_a] != 8'h01) |=>
    (pc == $past(pc) + 16'h0002 + {{8{$past(opd[7])}}, $past(opd)}))
    else $error("Loop branch went to the wrong address");

  a_loop_fall:
  assert property (@(posedge core_clk) disable iff (rst)
    (state == ST_EXEC && kind == K_LOOP && mem[work_a] == 8'h01) |=>
    (pc == $past(pc) + 16'h0002 && mem[$past(work_a)] == 8'h00))
    else $error("Loop did not fall through at zero");

  a_flags_held:
  assert property (@(posedge core_clk) disable iff (rst)
    (state == ST_EXEC && (kind == K_OFF || kind == K_ON ||
     kind == K_HALT || (kind == K_LOOP &&
     work_a != `IDC_FLAGS_IDX))) |=> $stable(flags_q))
    else $error("Control operation changed the flags");

  // halt gates the clock and stays until woken
  a_halt_gates:
  assert property (@(posedge core_clk) disable iff (rst)
    (state == ST_EXEC && kind == K_HALT) |=>
    (state == ST_HALT && !cpu_clk_en) ##1
    (state == ST_HALT || $past(irq_wake)))
    else $error("Halt did not stop the core clock");

  // wake from halt in one cycle
  a_halt_wake:
  assert property (@(posedge core_clk) disable iff (rst)
    (state == ST_HALT && irq_wake) |=> (state == ST_IDLE && cpu_clk_en))
    else $error("Interrupt did not end halt");

  // stack pointer three on after return
  a_ret_stack:
  assert property (@(posedge core_clk) disable iff (rst)
    (state == ST_EXEC && kind == K_RET) |=> ##1
    (stack_lo_q == $past(stack_lo_q, 2) + 8'h03 && irq_global_en))
    else $error("Return left the stack pointer wrong");
endmodule

// >>> sim/tb_top.sv
/*
  Self-checking bench for the step, loop, halt and interrupt slice.
  Assumes idc_core with its Wishbone slave and the constants header.
*/
`timescale 1ns/1ps
`include "idc_consts.svh"
module tb_top
  import idc_pkg::*;
;
  logic        core_clk;
  logic        rst;
  logic        wb_cyc_i;
  logic        wb_stb_i;
  logic        wb_we_i;
  logic [11:0] wb_adr_i;
  logic [3:0]  wb_sel_i;
  logic [31:0] wb_dat_i;
  logic [31:0] wb_dat_o;
  logic        wb_ack_o;
  logic        irq_wake;
  logic        cpu_clk_en;
  logic        irq_global_en;
  int          n_mismatch;
  int          checked;
  int          cycles;
  logic [31:0] tmp;
  logic [3:0]  sel_req;

  idc_core #(.ADR_W(12)) u_idc_core (
    .core_clk      (core_clk),
    .rst           (rst),
    .wb_cyc_i      (wb_cyc_i),
    .wb_stb_i      (wb_stb_i),
    .wb_we_i       (wb_we_i),
    .wb_adr_i      (wb_adr_i),
    .wb_sel_i      (wb_sel_i),
    .wb_dat_i      (wb_dat_i),
    .wb_dat_o      (wb_dat_o),
    .wb_ack_o      (wb_ack_o),
    .irq_wake      (irq_wake),
    .cpu_clk_en    (cpu_clk_en),
    .irq_global_en (irq_global_en)
  );

  // Clock at 25 MHz
  always #20 core_clk = ~core_clk;

  // Watchdog against a hung handshake
  always @(posedge core_clk)
  begin
    cycles++;
    if (cycles == 6000)
    begin
      n_mismatch++;
      $display("unexpected at %0t: timeout", $time);
      stop_test();
    end
  end

  task stop_test();
    $display("compares %0d mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  task chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask

  // One classic cycle; held until ack is sampled, then released
  task xfer(input logic we, input logic [11:0] adr,
            input logic [31:0] wd, output logic [31:0] rd);
    int n;
    @(posedge core_clk);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= we;
    wb_sel_i <= sel_req;
    wb_adr_i <= adr;
    wb_dat_i <= wd;
    n = 0;
    do
    begin
      @(posedge core_clk);
      n++;
    end
    while (wb_ack_o !== 1'b1 && n < 40);
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i  <= 1'b0;
    if (n >= 40)
      chk(32'h0, 32'h1);
  endtask

  task wreg(input logic [7:0] r, input logic [7:0] v);
    xfer(1'b1, {2'b00, r, 2'b00}, {24'h0, v}, tmp);
  endtask

  task creg(input logic [7:0] r, input logic [7:0] v);
    xfer(1'b0, {2'b00, r, 2'b00}, 32'h0, tmp);
    chk(tmp, {24'h0, v});
  endtask

  // Issue one instruction; the status read waits out execution
  task ex(input logic [7:0] op, input logic [7:0] opd);
    xfer(1'b1, `IDC_CMD_ADR, {16'h0, opd, op}, tmp);
    xfer(1'b0, `IDC_STAT_ADR, 32'h0, tmp);
  endtask

  task cpc(input logic [15:0] v);
    xfer(1'b0, `IDC_PC_ADR, 32'h0, tmp);
    chk(tmp, {16'h0, v});
  endtask

  task t_reset_map();
    creg(`IDC_IRQ_MASK_IDX, 8'h00);
    creg(`IDC_FLAGS_IDX, 8'h00);
    creg(`IDC_STACK_LO_IDX, 8'h00);
    chk({31'h0, irq_global_en}, 32'h0);
    wreg(`IDC_STACK_LO_IDX, 8'h5a);
    creg(`IDC_STACK_LO_IDX, 8'h5a);
    // A write with lane 0 off is acked but leaves the byte alone
    sel_req = 4'h0;
    wreg(`IDC_STACK_LO_IDX, 8'h11);
    sel_req = 4'hf;
    creg(`IDC_STACK_LO_IDX, 8'h5a);
    // Unmapped place reads zero and drops writes
    xfer(1'b1, 12'h40c, 32'h0000_00ff, tmp);
    xfer(1'b0, 12'h40c, 32'h0, tmp);
    chk(tmp, 32'h0);
    $display("test reset_map done");
  endtask

  task t_inc_byte();
    wreg(8'h30, 8'h7f);
    wreg(`IDC_FLAGS_IDX, 8'hec);
    ex(OPC_INC_R, 8'h30);
    creg(8'h30, 8'h80);
    creg(`IDC_FLAGS_IDX, 8'hbc);
    wreg(8'h31, 8'hff);
    wreg(8'h40, 8'h31);
    ex(OPC_INC_IR, 8'h40);
    creg(8'h31, 8'h00);
    creg(`IDC_FLAGS_IDX, 8'hcc);
    cpc(16'h0004);
    // Short working-register form, one byte long
    ex(8'h3e, 8'h00);
    creg(8'h03, 8'h01);
    creg(`IDC_FLAGS_IDX, 8'h8c);
    cpc(16'h0005);
    $display("test inc_byte done");
  endtask

  task t_word();
    wreg(8'h30, 8'h7f);
    wreg(8'h31, 8'hff);
    wreg(`IDC_FLAGS_IDX, 8'h00);
    ex(OPC_PINC_RR, 8'h30);
    creg(8'h30, 8'h80);
    creg(8'h31, 8'h00);
    creg(`IDC_FLAGS_IDX, 8'h30);
    ex(OPC_PDEC_RR, 8'h30);
    creg(8'h30, 8'h7f);
    creg(`IDC_FLAGS_IDX, 8'h10);
    wreg(`IDC_RPTR_IDX, 8'h50);
    wreg(8'h50, 8'h60);
    wreg(8'h60, 8'hff);
    wreg(8'h61, 8'hff);
    wreg(`IDC_FLAGS_IDX, 8'h8c);
    ex(OPC_PINC_IR, 8'he0);
    creg(8'h60, 8'h00);
    creg(`IDC_FLAGS_IDX, 8'hcc);
    ex(OPC_PDEC_IR, 8'he0);
    creg(8'h61, 8'hff);
    creg(`IDC_FLAGS_IDX, 8'hac);
    $display("test word done");
  endtask

  task t_irq();
    wreg(`IDC_IRQ_MASK_IDX, 8'h0a);
    wreg(`IDC_FLAGS_IDX, 8'hfc);
    ex(OPC_IRQ_ON, 8'h00);
    creg(`IDC_IRQ_MASK_IDX, 8'h8a);
    chk({31'h0, irq_global_en}, 32'h1);
    ex(OPC_IRQ_OFF, 8'h00);
    creg(`IDC_IRQ_MASK_IDX, 8'h0a);
    chk({31'h0, irq_global_en}, 32'h0);
    creg(`IDC_FLAGS_IDX, 8'hfc);
    $display("test irq done");
  endtask

  task t_loop();
    wreg(`IDC_RPTR_IDX, 8'h50);
    wreg(8'h52, 8'h02);
    wreg(`IDC_FLAGS_IDX, 8'ha8);
    xfer(1'b1, `IDC_PC_ADR, 32'h0000_0100, tmp);
    ex({4'h2, `IDC_LOOP_NIB}, 8'hfe);
    creg(8'h52, 8'h01);
    cpc(16'h0100);
    ex({4'h2, `IDC_LOOP_NIB}, 8'hfe);
    creg(8'h52, 8'h00);
    cpc(16'h0102);
    wreg(8'h52, 8'h05);
    xfer(1'b1, `IDC_PC_ADR, 32'h0000_0200, tmp);
    ex({4'h2, `IDC_LOOP_NIB}, 8'h7f);
    cpc(16'h0281);
    xfer(1'b1, `IDC_PC_ADR, 32'h0000_0200, tmp);
    ex({4'h2, `IDC_LOOP_NIB}, 8'h80);
    cpc(16'h0182);
    creg(8'h52, 8'h03);
    creg(`IDC_FLAGS_IDX, 8'ha8);
    $display("test loop done");
  endtask

  task t_return_from_isr_op();
    wreg(`IDC_STACK_LO_IDX, 8'h45);
    wreg(8'h45, 8'ha4);
    wreg(8'h46, 8'h6f);
    wreg(8'h47, 8'he4);
    wreg(`IDC_IRQ_MASK_IDX, 8'h0a);
    wreg(`IDC_FLAGS_IDX, 8'h00);
    ex(OPC_RET_ISR, 8'h00);
    creg(`IDC_FLAGS_IDX, 8'ha4);
    cpc(16'h6fe4);
    creg(`IDC_STACK_LO_IDX, 8'h48);
    creg(`IDC_IRQ_MASK_IDX, 8'h8a);
    // Instruction port reads back the last opcode and operand
    xfer(1'b0, `IDC_CMD_ADR, 32'h0, tmp);
    chk(tmp, 32'h0000_00bf);
    $display("test return_from_isr_op done");
  endtask

  task t_halt();
    xfer(1'b1, `IDC_PC_ADR, 32'h0000_0010, tmp);
    wreg(`IDC_FLAGS_IDX, 8'h64);
    // Halt issued straight after a write, no filler before it
    ex(OPC_HALT, 8'h00);
    chk(tmp, 32'h1);
    chk({31'h0, cpu_clk_en}, 32'h0);
    creg(`IDC_FLAGS_IDX, 8'h64);
    cpc(16'h0011);
    // Counter and instruction port refuse writes while halted
    xfer(1'b1, `IDC_PC_ADR, 32'h0000_0055, tmp);
    cpc(16'h0011);
    ex(OPC_IRQ_OFF, 8'h00);
    chk(tmp, 32'h1);
    chk({31'h0, irq_global_en}, 32'h1);
    @(posedge core_clk);
    irq_wake <= 1'b1;
    @(posedge core_clk);
    @(posedge core_clk);
    chk({31'h0, cpu_clk_en}, 32'h1);
    irq_wake <= 1'b0;
    xfer(1'b0, `IDC_STAT_ADR, 32'h0, tmp);
    chk(tmp, 32'h0);
    ex(OPC_HALT, 8'h00);
    chk({31'h0, cpu_clk_en}, 32'h0);
    @(posedge core_clk);
    rst <= 1'b1;
    repeat (2) @(posedge core_clk);
    rst <= 1'b0;
    @(posedge core_clk);
    @(posedge core_clk);
    chk({31'h0, cpu_clk_en}, 32'h1);
    cpc(16'h0000);
    $display("test halt done");
  endtask

  // Main sequence
  initial
  begin
    core_clk = 1'b0;
    rst = 1'b1;
    wb_cyc_i = 1'b0;
    wb_stb_i = 1'b0;
    wb_we_i = 1'b0;
    wb_adr_i = 12'h000;
    wb_sel_i = 4'hf;
    sel_req = 4'hf;
    wb_dat_i = 32'h0;
    irq_wake = 1'b0;
    n_mismatch = 0;
    checked = 0;
    cycles = 0;
    repeat (8) @(posedge core_clk);
    rst <= 1'b0;
    t_reset_map();
    t_inc_byte();
    t_word();
    t_irq();
    t_loop();
    t_return_from_isr_op();
    t_halt();
    stop_test();
  end
endmodule
